// ### rtl/fcsm_defines.svh
// holds command codes, unlock addresses, status bit positions and bus timing for the flash host
// assumes word-mode flash with 22 address bits and 16 data bits
`ifndef FCSM_DEFINES_SVH
`define FCSM_DEFINES_SVH
// ==========================================================
// flash command codes
`define FCSM_UNLOCK1_DATA 16'h00aa
`define FCSM_UNLOCK2_DATA 16'h0055
`define FCSM_UNLOCK1_ADDR 22'h000555
`define FCSM_UNLOCK2_ADDR 22'h0002aa
`define FCSM_CMD_RESET 16'h00f0
`define FCSM_CMD_IDENT 16'h0090
`define FCSM_CMD_PROG 16'h00a0
`define FCSM_CMD_BUFLOAD 16'h0025
`define FCSM_CMD_CONFIRM 16'h0029
`define FCSM_BUF_MAX 5'd16
// ==========================================================
// status bits read back on the data bus
`define FCSM_BIT_POLL 7
`define FCSM_BIT_TOGGLE 6
`define FCSM_BIT_TLIMIT 5
`define FCSM_BIT_BABORT 1
// ==========================================================
// host registers, byte addresses on the wishbone side
`define FCSM_REG_CTRL 4'h0
`define FCSM_REG_ADDR 4'h4
`define FCSM_REG_DATA 4'h8
`define FCSM_REG_STAT 4'hc
// ctrl write: [2:0] operation, [8:4] count minus one; write starts it
`define FCSM_OP_READ 3'd0
`define FCSM_OP_RESET 3'd1
`define FCSM_OP_IDENT 3'd2
`define FCSM_OP_PROG 3'd3
`define FCSM_OP_BUFPROG 3'd4
`define FCSM_OP_ABORTRST 3'd5
// ==========================================================
// flash strobe timing: we stays low for the count plus one clock (48 ns), then 3 high;
// read count 90 ns -> 12 clocks, so oe stays low 13 clocks
`define FCSM_T_WE_NS 40
`define FCSM_T_ACC_NS 90
`define FCSM_CLK_NS 8
`define FCSM_WE_CYC 4'((`FCSM_T_WE_NS + `FCSM_CLK_NS - 1) / `FCSM_CLK_NS)
`define FCSM_ACC_CYC 4'((`FCSM_T_ACC_NS + `FCSM_CLK_NS - 1) / `FCSM_CLK_NS)
`endif

// ### rtl/fcsm_pkg.sv
// holds the shared types of the flash host
// assumes the defines header is included by the files that need numbers
package fcsm_pkg;
  typedef logic [21:0] fcsm_addr_t;
  typedef logic [15:0] fcsm_data_t;
endpackage

// ### rtl/fcsm_cyc_if.sv
// carries one flash bus cycle request between sequencer and pin driver
// assumes a single clock shared by both ends
`timescale 1ns/1ns
interface fcsm_cyc_if;
  import fcsm_pkg::*;
  logic req;
  logic wr;
  fcsm_addr_t addr;
  fcsm_data_t wdata;
  fcsm_data_t rdata;
  logic done;
  modport seq (output req, output wr, output addr, output wdata, input rdata, input done);
  modport pin (input req, input wr, input addr, input wdata, output rdata, output done);
endinterface

// ### rtl/fcsm_pin.sv
// drives one flash read or write cycle on the parallel pins
// assumes flash inputs are synchronous to clk
`timescale 1ns/1ns
`include "fcsm_defines.svh"
module fcsm_pin (
  input wire logic clk,
  input wire logic rst_n,
  fcsm_cyc_if.pin cyc,
  output logic ce_n_r,
  output logic we_n_r,
  output logic oe_n_r,
  output fcsm_pkg::fcsm_addr_t fa_r,
  output fcsm_pkg::fcsm_data_t fd_o_r,
  output logic fd_oe_r,
  input wire fcsm_pkg::fcsm_data_t fd_i
);
  import fcsm_pkg::*;
  logic [3:0] cnt_r;
  logic busy_r;
  // ==========================================================
  // strobe timing; data latched by the flash at the we rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      fa_r <= '0;
      fd_o_r <= '0;
      fd_oe_r <= 1'b0;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      if (!busy_r && cyc.req && !cyc.done) begin
        busy_r <= 1'b1;
        fa_r <= cyc.addr;
        fd_o_r <= cyc.wdata;
        fd_oe_r <= cyc.wr;
        ce_n_r <= 1'b0;
        we_n_r <= !cyc.wr;
        oe_n_r <= cyc.wr;
        cnt_r <= cyc.wr ? `FCSM_WE_CYC : `FCSM_ACC_CYC;
      end else if (busy_r) begin
        if (cnt_r != 4'h0) begin
          cnt_r <= cnt_r - 4'h1;
        end else begin
          // release strobes; read sample taken before oe rises
          cyc.rdata <= fd_i;
          we_n_r <= 1'b1;
          oe_n_r <= 1'b1;
          ce_n_r <= 1'b1;
          fd_oe_r <= 1'b0;
          busy_r <= 1'b0;
          cyc.done <= 1'b1;
        end
      end
    end
  end
endmodule

// ### rtl/fcsm_host.sv
// flash host: software orders operations over wishbone, sequencer issues flash command cycles
// assumes a word-mode flash on the pins; one clock, inputs synchronous
`timescale 1ns/1ns
`include "fcsm_defines.svh"
module fcsm_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output fcsm_pkg::fcsm_addr_t flash_addr,
  output fcsm_pkg::fcsm_data_t flash_data_o,
  output logic flash_data_oe,
  input wire fcsm_pkg::fcsm_data_t flash_data_i,
  input wire logic ready_busy_out
);
  import fcsm_pkg::*;
  typedef enum logic [7:0] {
    ST_IDLE = 8'b00000001,
    ST_CMD = 8'b00000010,
    ST_LOAD = 8'b00000100,
    ST_POLL = 8'b00001000,
    ST_DONE = 8'b00010000
  } fcsm_state_e;

  fcsm_cyc_if cyc ();
  fcsm_state_e state_r;
  logic [2:0] op_r;
  logic [4:0] cnt_r;
  logic [2:0] step_r;
  fcsm_addr_t addr_r;
  fcsm_data_t data_r;
  fcsm_data_t rd_r;
  fcsm_addr_t poll_addr_r;
  logic [15:0] prev_r;
  logic have_prev_r;
  logic busy_r;
  logic err_r;
  logic data_wr_stb;
  logic go_stb;

  // ==========================================================
  // pin driver
  fcsm_pin u_pin (
    .clk(clk),
    .rst_n(rst_n),
    .cyc(cyc.pin),
    .ce_n_r(ce_n),
    .we_n_r(we_n),
    .oe_n_r(oe_n),
    .fa_r(flash_addr),
    .fd_o_r(flash_data_o),
    .fd_oe_r(flash_data_oe),
    .fd_i(flash_data_i)
  );

  // sequence step table: address and data of step n for the current operation
  function automatic logic [37:0] step_ad(input logic [2:0] op, input logic [2:0] n,
                                          input fcsm_addr_t a, input fcsm_data_t d,
                                          input logic [4:0] c);
    fcsm_addr_t sa;
    sa = {a[21:12], 12'h000};
    step_ad = '0;
    case (n)
      // a lone reset is a single cycle, so its step 0 carries the reset command itself
      3'd0: step_ad = (op == `FCSM_OP_RESET) ? {`FCSM_UNLOCK1_ADDR, `FCSM_CMD_RESET}
                      : {`FCSM_UNLOCK1_ADDR, `FCSM_UNLOCK1_DATA};
      3'd1: step_ad = {`FCSM_UNLOCK2_ADDR, `FCSM_UNLOCK2_DATA};
      3'd2: begin
        case (op)
          `FCSM_OP_IDENT: step_ad = {`FCSM_UNLOCK1_ADDR, `FCSM_CMD_IDENT};
          `FCSM_OP_PROG: step_ad = {`FCSM_UNLOCK1_ADDR, `FCSM_CMD_PROG};
          `FCSM_OP_BUFPROG: step_ad = {sa, `FCSM_CMD_BUFLOAD};
          default: step_ad = {`FCSM_UNLOCK1_ADDR, `FCSM_CMD_RESET};
        endcase
      end
      3'd3: begin
        if (op == `FCSM_OP_PROG) begin
          step_ad = {a, d};
        end else begin
          step_ad = {sa, 11'h000, c};
        end
      end
      default: step_ad = {sa, `FCSM_CMD_CONFIRM};
    endcase
  endfunction

  // number of command cycles before loads or polling
  function automatic logic [2:0] step_cnt(input logic [2:0] op);
    case (op)
      `FCSM_OP_PROG: step_cnt = 3'd4;
      `FCSM_OP_BUFPROG: step_cnt = 3'd4;
      `FCSM_OP_IDENT: step_cnt = 3'd3;
      `FCSM_OP_ABORTRST: step_cnt = 3'd3;
      default: step_cnt = 3'd1;
    endcase
  endfunction

  // ==========================================================
  // wishbone slave: one wait state, more for data writes in load state while a flash cycle is pending; ack drops after one cycle; writes act on the ack edge
  assign go_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
                  && wb_adr_i == `FCSM_REG_CTRL && !busy_r;
  assign data_wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                       && wb_adr_i == `FCSM_REG_DATA && state_r == ST_LOAD && !cyc.req;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      // writes to data in load state hold ack while the previous flash cycle is still pending
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o
                  && !(wb_we_i && wb_adr_i == `FCSM_REG_DATA && state_r == ST_LOAD
                       && cyc.req);
      case (wb_adr_i)
        `FCSM_REG_ADDR: wb_dat_o <= {10'h000, addr_r};
        `FCSM_REG_DATA: wb_dat_o <= {16'h0000, rd_r};
        `FCSM_REG_STAT: wb_dat_o <= {24'h000000, ready_busy_out, err_r, 1'b0, cnt_r[4],
                                     3'b000, busy_r};
        default: wb_dat_o <= {24'h000000, state_r};
      endcase
    end
  end

  // address register; data register written outside the load state holds program data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= '0;
      data_r <= '0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      if (wb_adr_i == `FCSM_REG_ADDR) begin
        addr_r <= wb_dat_i[21:0];
      end else if (wb_adr_i == `FCSM_REG_DATA && state_r != ST_LOAD) begin
        data_r <= wb_dat_i[15:0];
      end
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      op_r <= `FCSM_OP_READ;
      cnt_r <= '0;
      step_r <= '0;
      busy_r <= 1'b0;
      err_r <= 1'b0;
      rd_r <= '0;
      poll_addr_r <= '0;
      prev_r <= '0;
      have_prev_r <= 1'b0;
      cyc.req <= 1'b0;
      cyc.wr <= 1'b0;
      cyc.addr <= '0;
      cyc.wdata <= '0;
    end else begin
      if (cyc.done) begin
        cyc.req <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (go_stb) begin
            op_r <= wb_dat_i[2:0];
            cnt_r <= wb_dat_i[8:4];
            step_r <= '0;
            busy_r <= 1'b1;
            err_r <= 1'b0;
            have_prev_r <= 1'b0;
            poll_addr_r <= addr_r;
            if (wb_dat_i[2:0] == `FCSM_OP_BUFPROG && wb_dat_i[8:4] >= `FCSM_BUF_MAX) begin
              err_r <= 1'b1;
              busy_r <= 1'b0;
            end else if (wb_dat_i[2:0] == `FCSM_OP_READ) begin
              // array read needs no command cycles
              cyc.req <= 1'b1;
              cyc.wr <= 1'b0;
              cyc.addr <= addr_r;
              state_r <= ST_DONE;
            end else begin
              state_r <= ST_CMD;
            end
          end
        end
        ST_CMD: begin
          if (!cyc.req && !cyc.done) begin
            if (op_r == `FCSM_OP_BUFPROG && step_r == 3'd6) begin
              // confirm is out; the flash now programs the buffer while we poll
              state_r <= ST_POLL;
            end else if (step_r == step_cnt(op_r)) begin
              if (op_r == `FCSM_OP_BUFPROG) begin
                state_r <= ST_LOAD;
              end else if (op_r == `FCSM_OP_PROG) begin
                state_r <= ST_POLL;
              end else begin
                // reset leaves identifier mode and clears timing limit
                busy_r <= 1'b0;
                state_r <= ST_IDLE;
              end
            end else begin
              {cyc.addr, cyc.wdata} <= step_ad(op_r, step_r, addr_r, data_r, cnt_r);
              cyc.wr <= 1'b1;
              cyc.req <= 1'b1;
              step_r <= step_r + 3'd1;
            end
          end
        end
        ST_LOAD: begin
          if (data_wr_stb) begin
            // each software data write is one load; page taken from addr_r[21:4], word from data bits 19:16
            cyc.addr <= {addr_r[21:4], wb_dat_i[19:16]};
            cyc.wdata <= wb_dat_i[15:0];
            cyc.wr <= 1'b1;
            cyc.req <= 1'b1;
            poll_addr_r <= {addr_r[21:4], wb_dat_i[19:16]};
            prev_r <= {wb_dat_i[15:0]};
            if (cnt_r == 5'd0) begin
              // step 5 sends the confirm; step 4 would fall back into the load state
              step_r <= 3'd5;
              state_r <= ST_CMD;
            end else begin
              cnt_r <= cnt_r - 5'd1;
            end
          end
        end
        ST_POLL: begin
          // toggle-bit polling at the program address, or the last loaded address for buffer programs
          if (!cyc.req && !cyc.done) begin
            cyc.req <= 1'b1;
            cyc.wr <= 1'b0;
            cyc.addr <= poll_addr_r;
          end else if (cyc.done) begin
            rd_r <= cyc.rdata;
            have_prev_r <= 1'b1;
            prev_r <= cyc.rdata;
            if (have_prev_r && cyc.rdata[`FCSM_BIT_TOGGLE] == prev_r[`FCSM_BIT_TOGGLE]) begin
              busy_r <= 1'b0;
              state_r <= ST_IDLE;
            end else if (cyc.rdata[`FCSM_BIT_BABORT]) begin
              err_r <= 1'b1;
              busy_r <= 1'b0;
              state_r <= ST_IDLE;
            end else if (cyc.rdata[`FCSM_BIT_TLIMIT]) begin
              err_r <= 1'b1;
              busy_r <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_DONE: begin
          if (cyc.done) begin
            rd_r <= cyc.rdata;
            busy_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ### verif/fcsm_host_properties.sv
// checker of flash host pin timing and bus handshake
// assumes binding into fcsm_host, one clock domain
`timescale 1ns/1ns
module fcsm_host_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire fcsm_pkg::fcsm_addr_t flash_addr,
  input wire fcsm_pkg::fcsm_data_t flash_data_o,
  input wire logic flash_data_oe
);
  import fcsm_pkg::*;
  // ==========================================
  // properties, off while reset is low
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_FIRST_IDLE: assert property ($rose(rst_n) |-> ce_n && we_n && oe_n)
    else $error("strobe active after reset");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  AST_WE_SEL: assert property (!we_n |-> !ce_n && oe_n)
    else $error("write strobe without select");
  AST_WE_WIDTH: assert property ($fell(we_n) |-> (!we_n) [*6] ##1 we_n)
    else $error("write strobe width");
  AST_WE_HOLD: assert property (!we_n && !$past(we_n) |->
    $stable(flash_addr) && $stable(flash_data_o) && flash_data_oe)
    else $error("write data moved");
  AST_BUS_FREE: assert property (!oe_n |-> !flash_data_oe)
    else $error("data driven in read");
  AST_OE_WIDTH: assert property ($fell(oe_n) |-> ##12 !oe_n ##1 oe_n)
    else $error("read strobe width");
  // main scenarios reached
  cover property ($fell(we_n));
  cover property ($fell(oe_n));
  cover property (wb_ack_o && wb_cyc_i);
endmodule
bind fcsm_host fcsm_host_props i_props (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
  .flash_addr(flash_addr), .flash_data_o(flash_data_o), .flash_data_oe(flash_data_oe));

// ### verif/fcsm_flash_model.sv
// behavioural flash command state machine on the host pins
// assumes word mode; array kept on the low address byte only
`timescale 1ns/1ns
module fcsm_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00a5, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h005a // arbitrary value
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire fcsm_pkg::fcsm_addr_t addr,
  input wire fcsm_pkg::fcsm_data_t din,
  input wire logic abort_req,
  output fcsm_pkg::fcsm_data_t dout,
  output logic ready_busy_out
);
  import fcsm_pkg::*;
  typedef enum {F_READ, F_U1, F_U2, F_IDENT, F_PROG, F_BCNT, F_BLOAD, F_BCONF, F_BUSY} fcsm_fst_e;
  fcsm_fst_e st = F_READ;
  fcsm_data_t mem [256], bd [16], dl, last, hold = '0;
  fcsm_addr_t al, ra;
  logic [15:0] bv;
  logic [9:0] sa;
  logic [17:0] pg;
  logic wsel, abt = 0, tgl = 0;
  int cnt, bsy, nwr = 0;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  assign ready_busy_out = st != F_BUSY;
  task fail_buf();
    abt = 1;
    st = F_READ;
  endtask
  // ==========================================
  // select, address and data all sampled 16 ns after the strobe fall, well inside the pulse
  always @(negedge we_n) begin
    #16 wsel = !ce_n;
    al = addr;
    dl = din;
  end
  // commands act at the strobe rise; abort keeps status until the abort reset
  always @(posedge we_n) if (wsel) begin
    nwr++;
    if (dl == 16'h00f0 && !abt && st != F_BUSY) st = F_READ;
    else case (st)
      F_BUSY: ;
      F_U1: st = (dl == 16'h0055 && al == 22'h0002aa) ? F_U2 : F_READ;
      F_U2: if (abt) begin
        abt = dl != 16'h00f0 || al != 22'h000555;
        st = F_READ;
      end else if (dl == 16'h0090) st = F_IDENT;
      else if (dl == 16'h00a0) st = F_PROG;
      else if (dl == 16'h0025) begin
        sa = al[21:12];
        st = F_BCNT;
      end else st = F_READ;
      F_PROG: begin
        mem[al[7:0]] &= dl;
        last = dl;
        bsy = 3;
        st = F_BUSY;
      end
      F_BCNT: begin
        cnt = dl;
        bv = '0;
        st = F_BLOAD;
        if (al[21:12] != sa || dl > 16'h000f) fail_buf();
      end
      F_BLOAD: begin
        last = dl;
        if (al[21:12] != sa || (bv != 0 && al[21:4] != pg)) fail_buf();
        else begin
          pg = al[21:4];
          bd[al[3:0]] = dl;
          bv[al[3:0]] = 1'h1;
          st = cnt == 0 ? F_BCONF : F_BLOAD;
          cnt--;
        end
      end
      F_BCONF: if (dl == 16'h0029 && al[21:12] == sa && !abort_req) begin
        foreach (bd[i]) if (bv[i]) mem[{pg[3:0], 4'(i)}] &= bd[i];
        bsy = 3;
        st = F_BUSY;
      end else fail_buf();
      default: if (dl == 16'h00aa && al == 22'h000555) st = F_U1;
    endcase
  end
  // each read while busy or aborted flips the toggle bit and counts busy time down
  always @(negedge oe_n) begin
    #8 ra = addr;
    if (!ce_n && (st == F_BUSY || abt)) begin
      tgl = !tgl;
      bsy--;
      if (bsy == 0 && !abt) st = F_READ;
    end
    #8 hold = dout;
  end
  // a released bus has no keeper, so it shows the inverse of the last value
  always_comb
    if (ce_n || oe_n) dout = ~hold;
    else if (st == F_BUSY || abt) dout = {8'h00, ~last[7], tgl, 4'h0, abt, 1'h0};
    else if (st != F_IDENT) dout = mem[ra[7:0]];
    else if (ra[7:0] == 8'h00) dout = MFR_CODE;
    else if (ra[7:0] == 8'h01) dout = DEV_CODE;
    else dout = {15'h0000, ra[7:0] == 8'h02 && ra[21:12] == 10'h003};
endmodule

// ### verif/flash_command_state_machine_test.sv
// bench: software side of the flash host over wishbone, flash model on the pins
// assumes the checker is bound into the host from its own file
`timescale 1ns/1ns
`include "fcsm_defines.svh"
module flash_command_state_machine_test;
  import fcsm_pkg::*;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, abort_req = 0;
  logic ack, ce_n, we_n, oe_n, fd_oe, rb;
  logic [3:0] adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  fcsm_addr_t fa;
  fcsm_data_t fdo, fdi;
  int miscompares = 0, tests_run = 0, n0;
  fcsm_host i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .flash_addr(fa), .flash_data_o(fdo),
    .flash_data_oe(fd_oe), .flash_data_i(fdi), .ready_busy_out(rb));
  fcsm_flash_model i_flash (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(fa), .din(fdo),
    .abort_req(abort_req), .dout(fdi), .ready_busy_out(rb));
  initial forever #4 clk = ~clk;
  // ==========================================
  // helpers: comparison, classic bus cycle, flash operations
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until ack is sampled; only the watchdog ends a stuck wait
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      wb(`FCSM_REG_STAT, 1'h0, 32'h0);
      n++;
    end while (q[0] !== 1'h0 && n < 400);
    chk("busy cleared", 16'h0000, {15'h0000, q[0]});
  endtask
  // loads are only taken once the sequencer stands in its load state
  task automatic wait_load();
    int n;
    n = 0;
    do begin
      wb(`FCSM_REG_CTRL, 1'h0, 32'h0);
      n++;
    end while (q[7:0] !== 8'h04 && n < 100);
    chk("load state", 16'h0004, {8'h00, q[7:0]});
  endtask
  task automatic op(input logic [2:0] o, input logic [4:0] c);
    wb(`FCSM_REG_CTRL, 1'h1, {23'h0, c, 1'h0, o});
    idle();
  endtask
  task automatic rd(input fcsm_addr_t a, input logic [15:0] exp, input string what);
    wb(`FCSM_REG_ADDR, 1'h1, {10'h0, a});
    op(`FCSM_OP_READ, 5'h00);
    wb(`FCSM_REG_DATA, 1'h0, 32'h0);
    chk(what, exp, q[15:0]);
  endtask
  task automatic prog(input fcsm_addr_t a, input logic [15:0] d);
    wb(`FCSM_REG_ADDR, 1'h1, {10'h0, a});
    wb(`FCSM_REG_DATA, 1'h1, {16'h0, d});
    op(`FCSM_OP_PROG, 5'h00);
  endtask
  // ==========================================
  // scenarios
  task automatic t_program();
    n0 = i_flash.nwr;
    rd(22'h000010, 16'hffff, "erased word");
    chk("read cycles", n0, i_flash.nwr);
    prog(22'h000010, 16'h5a3c);
    chk("program cycles", n0 + 4, i_flash.nwr);
    chk("ready after program", 1'h1, q[7]);
    rd(22'h000010, 16'h5a3c, "programmed word");
    prog(22'h000010, 16'hff0f);
    rd(22'h000010, 16'h5a0c, "zeros kept");
  endtask
  task automatic t_ident();
    op(`FCSM_OP_IDENT, 5'h00);
    rd(22'h000000, i_flash.MFR_CODE, "maker code");
    rd(22'h000301, i_flash.DEV_CODE, "device code");
    rd(22'h003002, 16'h0001, "protected sector");
    rd(22'h004002, 16'h0000, "open sector");
    op(`FCSM_OP_RESET, 5'h00);
    rd(22'h000010, 16'h5a0c, "array after reset");
  endtask
  // three loads for two places: the reloaded place keeps its last data
  task automatic t_buffer();
    wb(`FCSM_REG_ADDR, 1'h1, 32'h0000_5020);
    wb(`FCSM_REG_CTRL, 1'h1, {23'h0, 5'h02, 1'h0, `FCSM_OP_BUFPROG});
    wait_load();
    wb(`FCSM_REG_DATA, 1'h1, 32'h0003_1111);
    wb(`FCSM_REG_DATA, 1'h1, 32'h0007_2222);
    wb(`FCSM_REG_DATA, 1'h1, 32'h0003_3333);
    idle();
    chk("buffer error", 1'h0, q[6]);
    rd(22'h005023, 16'h3333, "reloaded word");
    rd(22'h005027, 16'h2222, "buffer word");
  endtask
  task automatic t_abort();
    abort_req <= 1'h1;
    wb(`FCSM_REG_ADDR, 1'h1, 32'h0000_5040);
    wb(`FCSM_REG_CTRL, 1'h1, {23'h0, 5'h00, 1'h0, `FCSM_OP_BUFPROG});
    wait_load();
    wb(`FCSM_REG_DATA, 1'h1, 32'h0001_00ff);
    idle();
    chk("abort error", 1'h1, q[6]);
    abort_req <= 1'h0;
    op(`FCSM_OP_ABORTRST, 5'h00);
    rd(22'h005027, 16'h2222, "array after abort reset");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk("idle strobes", 3'h7, {ce_n, we_n, oe_n});
    t_program();
    t_ident();
    t_buffer();
    t_abort();
    finish_test();
  end
  // watchdog: about a thousand cycles are expected, this is far beyond
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule
